// ---- logic/ddsfsk_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - 24-bit phase accumulator advances once every reference clock cycle outside standby; standby holds the phase.
// - Accumulator adds active word; phase indexes a sine table feeding the DAC.
// - Two 22-bit words, zero-extended into 24-bit register; the FSK deviation add can carry into the top two bits.
// - Mode select pin chooses which word loads the frequency register.
// - Modulation select low enables FSK with an 8-bit deviation.
// - Deviation times four is added while transmit data is high.
// - Frequency words are static and survive standby.
// - Feedback divider ratio is either 256 or 512.
// - Acquisition-aid pump runs only while unlocked.
// - Three-bit field sets acquisition-aid current factor.
// - Learning integrates threshold; hold freezes it and slices against it.
// - Hold opens the tuning loop; external threshold may govern slicing.
module ddsfsk_top #(
	parameter int DAC_W = 11
) (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire logic                       mode_select,
	input  wire logic                       tx_data,
	input  wire logic                       standby,
	input  wire logic                       pll_lock,
	input  wire logic [ddsfsk_pkg::SMP_W-1:0] demod_sample,
	input  wire logic [ddsfsk_pkg::SMP_W-1:0] threshold_hold_node,
	output logic      [DAC_W-1:0]           dac_out,
	output logic      [ddsfsk_pkg::DIV_W-1:0] div_ratio,
	output logic                            acq_pump_out,
	output logic      [ddsfsk_pkg::GAIN_W-1:0] acq_aid_gain,
	output logic                            osc_enable,
	output logic      [ddsfsk_pkg::SMP_W-1:0] afc_tune,
	output logic                            data_out
);
	localparam int AW = ddsfsk_pkg::ACC_W;
	localparam int WW = ddsfsk_pkg::WORD_W;
	localparam int SW = ddsfsk_pkg::SMP_W;

	ddsfsk_pkg::ddsfsk_aphase_s ap_r;
	ddsfsk_pkg::ddsfsk_aphase_s ap_nxt;
	ddsfsk_pkg::ddsfsk_cfg_s    cfg_r;
	ddsfsk_pkg::ddsfsk_cfg_s    cfg_nxt;
	logic [WW-1:0]              freq_word_mode0_r;
	logic [WW-1:0]              freq_word_mode0_nxt;
	logic [WW-1:0]              freq_word_mode1_r;
	logic [WW-1:0]              freq_word_mode1_nxt;
	logic [AW-1:0]              freq_reg_r;
	logic [AW-1:0]              freq_reg_nxt;
	logic [31:0]                hrdata_nxt;
	logic [SW-1:0]              thr_r;
	logic [SW-1:0]              thr_nxt;
	logic [SW-1:0]              afc_nxt;
	logic                       data_nxt;
	logic [SW-1:0]              thr_use;
	logic [2:0]                 pins_sync;
	logic                       mode_s;
	logic                       tx_s;
	logic                       lock_s;
	logic [AW-1:0]              phase;
	logic [DAC_W-1:0]           dac_w;
	logic [AW-1:0]              word_sel;
	logic                       wr_en;

	function automatic logic [31:0] cfg_word(input ddsfsk_pkg::ddsfsk_cfg_s c);
		cfg_word = '0;
		cfg_word[ddsfsk_pkg::CFG_DEVN_LSB +: ddsfsk_pkg::DEVN_W] = c.deviation;
		cfg_word[ddsfsk_pkg::CFG_GAIN_LSB +: ddsfsk_pkg::GAIN_W] = c.acq_gain;
		cfg_word[ddsfsk_pkg::CFG_DIV512]  = c.div512;
		cfg_word[ddsfsk_pkg::CFG_OSC_EN]  = c.osc_enable;
		cfg_word[ddsfsk_pkg::CFG_HOLD]    = c.hold;
		cfg_word[ddsfsk_pkg::CFG_EXT_THR] = c.ext_thr;
		cfg_word[ddsfsk_pkg::CFG_MODSEL]  = c.modulation_select;
	endfunction

	function automatic ddsfsk_pkg::ddsfsk_cfg_s cfg_unpack(input logic [31:0] w);
		cfg_unpack.deviation         = w[ddsfsk_pkg::CFG_DEVN_LSB +: ddsfsk_pkg::DEVN_W];
		cfg_unpack.acq_gain          = w[ddsfsk_pkg::CFG_GAIN_LSB +: ddsfsk_pkg::GAIN_W];
		cfg_unpack.div512            = w[ddsfsk_pkg::CFG_DIV512];
		cfg_unpack.osc_enable        = w[ddsfsk_pkg::CFG_OSC_EN];
		cfg_unpack.hold              = w[ddsfsk_pkg::CFG_HOLD];
		cfg_unpack.ext_thr           = w[ddsfsk_pkg::CFG_EXT_THR];
		cfg_unpack.modulation_select = w[ddsfsk_pkg::CFG_MODSEL];
	endfunction

	ddsfsk_sync #(
		.W(ddsfsk_pkg::SYNC_W)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.async_in({pll_lock, tx_data, mode_select}),
		.sync_out(pins_sync)
	);

	assign mode_s = pins_sync[0];
	assign tx_s   = pins_sync[1];
	assign lock_s = pins_sync[2];

	ddsfsk_nco #(
		.ACC_W(AW),
		.DAC_W(DAC_W)
	) u_nco (
		.hclk   (hclk),
		.hresetn(hresetn),
		.run    (!standby),
		.freq   (freq_reg_r),
		.phase  (phase),
		.dac    (dac_w)
	);

	// Bus slave: zero wait state, always OKAY
	always_comb begin
		ap_nxt = ap_r;
		if (hready) begin
			ap_nxt.valid = hsel && htrans[1];
			ap_nxt.write = hwrite;
			ap_nxt.addr  = {haddr[7:2], 2'b00};
		end
		wr_en = ap_r.valid && ap_r.write;
		freq_word_mode0_nxt = freq_word_mode0_r;
		freq_word_mode1_nxt = freq_word_mode1_r;
		cfg_nxt = cfg_r;
		// Words change only by bus write, standby leaves them untouched
		if (wr_en) begin
			unique case (ap_r.addr)
				ddsfsk_pkg::OFS_FREQ0: freq_word_mode0_nxt = hwdata[WW-1:0];
				ddsfsk_pkg::OFS_FREQ1: freq_word_mode1_nxt = hwdata[WW-1:0];
				ddsfsk_pkg::OFS_CFG:   cfg_nxt = cfg_unpack(hwdata);
				default: ;
			endcase
		end
		// Read data from next values so a write just before is seen
		hrdata_nxt = hrdata;
		if (hready && hsel && htrans[1] && !hwrite) begin
			unique case ({haddr[7:2], 2'b00})
				ddsfsk_pkg::OFS_FREQ0:  hrdata_nxt = {10'h000, freq_word_mode0_nxt};
				ddsfsk_pkg::OFS_FREQ1:  hrdata_nxt = {10'h000, freq_word_mode1_nxt};
				ddsfsk_pkg::OFS_CFG:    hrdata_nxt = cfg_word(cfg_nxt);
				ddsfsk_pkg::OFS_STATUS: hrdata_nxt = {28'h0000000, acq_pump_out, tx_s,
					mode_s, lock_s};
				ddsfsk_pkg::OFS_PHASE:  hrdata_nxt = {8'h00, phase};
				ddsfsk_pkg::OFS_SLICER: hrdata_nxt = {16'h0000, afc_tune, thr_r};
				default:                hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r              <= '0;
			freq_word_mode0_r <= ddsfsk_pkg::FREQ_RST;
			freq_word_mode1_r <= ddsfsk_pkg::FREQ_RST;
			cfg_r             <= cfg_unpack(ddsfsk_pkg::CFG_RST);
			hrdata            <= 32'h0000_0000;
			hreadyout         <= 1'b1;
			hresp             <= 1'b0;
		end else begin
			ap_r              <= ap_nxt;
			freq_word_mode0_r <= freq_word_mode0_nxt;
			freq_word_mode1_r <= freq_word_mode1_nxt;
			cfg_r             <= cfg_nxt;
			hrdata            <= hrdata_nxt;
			hreadyout         <= 1'b1;
			hresp             <= 1'b0;
		end
	end

	// Frequency register and PLL controls
	always_comb begin
		word_sel = {2'b00, mode_s ? freq_word_mode1_r : freq_word_mode0_r};
		freq_reg_nxt = word_sel;
		if (!cfg_r.modulation_select && tx_s) begin
			freq_reg_nxt = AW'(word_sel + {14'h0000, cfg_r.deviation, 2'b00});
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_reg_r   <= '0;
			div_ratio    <= ddsfsk_pkg::DIV_LOW;
			acq_pump_out <= 1'b0;
			acq_aid_gain <= '0;
			osc_enable   <= 1'b1;
			dac_out      <= DAC_W'(11'h400);
		end else begin
			freq_reg_r   <= freq_reg_nxt;
			div_ratio    <= cfg_r.div512 ? ddsfsk_pkg::DIV_HIGH : ddsfsk_pkg::DIV_LOW;
			acq_pump_out <= !lock_s;
			acq_aid_gain <= cfg_r.acq_gain;
			osc_enable   <= cfg_r.osc_enable;
			dac_out      <= dac_w;
		end
	end

	// Slicer: learning tracks the mean, hold freezes threshold and tuning
	always_comb begin
		thr_nxt = thr_r;
		afc_nxt = afc_tune;
		if (!cfg_r.hold) begin
			thr_nxt = SW'($signed({1'b0, thr_r}) + (($signed({1'b0, demod_sample})
				- $signed({1'b0, thr_r})) >>> ddsfsk_pkg::THR_SHIFT));
			afc_nxt = thr_nxt;
		end
		thr_use  = (cfg_r.hold && cfg_r.ext_thr) ? threshold_hold_node : thr_r;
		data_nxt = demod_sample > thr_use;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thr_r    <= ddsfsk_pkg::THR_RST;
			afc_tune <= ddsfsk_pkg::THR_RST;
			data_out <= 1'b0;
		end else begin
			thr_r    <= thr_nxt;
			afc_tune <= afc_nxt;
			data_out <= data_nxt;
		end
	end

	property p_acc_step;
		@(posedge hclk) disable iff (!hresetn)
		!standby |=> phase == AW'($past(phase) + $past(freq_reg_r));
	endproperty
	a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

	property p_acc_hold;
		@(posedge hclk) disable iff (!hresetn)
		standby |=> $stable(phase);
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved in standby");

	property p_top_bits;
		@(posedge hclk) disable iff (!hresetn)
		cfg_r.modulation_select |=> freq_reg_r[AW-1 -: 2] == 2'b00;
	endproperty
	a_top_bits: assert property (p_top_bits) else $error("frequency top bits set");

	property p_mode_word;
		@(posedge hclk) disable iff (!hresetn)
		(cfg_r.modulation_select || !tx_s) |=>
			freq_reg_r == {2'b00, $past(mode_s) ? $past(freq_word_mode1_r)
			: $past(freq_word_mode0_r)};
	endproperty
	a_mode_word: assert property (p_mode_word) else $error("wrong mode word");

	property p_fsk_dev;
		@(posedge hclk) disable iff (!hresetn)
		(!cfg_r.modulation_select && tx_s) |=> freq_reg_r == AW'({2'b00, $past(mode_s)
			? $past(freq_word_mode1_r) : $past(freq_word_mode0_r)}
			+ {14'h0000, $past(cfg_r.deviation), 2'b00});
	endproperty
	a_fsk_dev: assert property (p_fsk_dev) else $error("deviation not applied");

	property p_tx_sync;
		@(posedge hclk) disable iff (!hresetn)
		##2 1'b1 |-> tx_s == $past(tx_data, 2);
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("transmit sync latency");

	property p_pump;
		@(posedge hclk) disable iff (!hresetn)
		lock_s |=> !acq_pump_out;
	endproperty
	a_pump: assert property (p_pump) else $error("pump on while locked");

	property p_div;
		@(posedge hclk) disable iff (!hresetn)
		##1 1'b1 |-> (div_ratio == (cfg_r.div512 ? 10'h200 : 10'h100))
			|| $changed(cfg_r.div512);
	endproperty
	a_div: assert property (p_div) else $error("divider ratio illegal");

	property p_retain;
		@(posedge hclk) disable iff (!hresetn)
		!wr_en |=> $stable(freq_word_mode0_r) && $stable(freq_word_mode1_r);
	endproperty
	a_retain: assert property (p_retain) else $error("word changed without write");

	property p_hold_thr;
		@(posedge hclk) disable iff (!hresetn)
		cfg_r.hold |=> $stable(thr_r) && $stable(afc_tune);
	endproperty
	a_hold_thr: assert property (p_hold_thr) else $error("threshold moved in hold");

	property p_gain;
		@(posedge hclk) disable iff (!hresetn)
		##1 1'b1 |-> acq_aid_gain == $past(cfg_r.acq_gain);
	endproperty
	a_gain: assert property (p_gain) else $error("gain field not forwarded");
endmodule

// ---- logic/ddsfsk_pkg.sv ----
package ddsfsk_pkg;
	localparam int ACC_W      = 24;
	localparam int WORD_W     = 22;
	localparam int DEVN_W     = 8;
	localparam int DEVN_SHIFT = 2;
	localparam int GAIN_W     = 3;
	localparam int DIV_W      = 10;
	localparam int SMP_W      = 8;

	localparam logic [7:0] OFS_FREQ0  = 8'h00;
	localparam logic [7:0] OFS_FREQ1  = 8'h04;
	localparam logic [7:0] OFS_CFG    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PHASE  = 8'h10;
	localparam logic [7:0] OFS_SLICER = 8'h14;

	localparam int CFG_DEVN_LSB  = 0;
	localparam int CFG_GAIN_LSB  = 8;
	localparam int CFG_DIV512    = 11;
	localparam int CFG_OSC_EN    = 12;
	localparam int CFG_HOLD      = 13;
	localparam int CFG_EXT_THR   = 14;
	localparam int CFG_MODSEL    = 16;

	localparam logic [WORD_W-1:0] FREQ_RST   = 22'h000000;
	localparam logic [31:0]       CFG_RST    = 32'h0001_1000;
	localparam logic [DIV_W-1:0]  DIV_LOW    = 10'h100;
	localparam logic [DIV_W-1:0]  DIV_HIGH   = 10'h200;
	localparam logic [SMP_W-1:0]  THR_RST    = 8'h80;
	localparam int                THR_SHIFT  = 4;
	localparam int                SYNC_W     = 3;

	typedef struct packed {
		logic [DEVN_W-1:0] deviation;
		logic [GAIN_W-1:0] acq_gain;
		logic              div512;
		logic              osc_enable;
		logic              hold;
		logic              ext_thr;
		logic              modulation_select;
	} ddsfsk_cfg_s;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ddsfsk_aphase_s;
endpackage

// ---- logic/ddsfsk_sync.sv ----
`timescale 1ns/1ns
module ddsfsk_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end
endmodule

// ---- logic/ddsfsk_nco.sv ----
`timescale 1ns/1ns
module ddsfsk_nco #(
	parameter int ACC_W = 24,
	parameter int DAC_W = 11
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             run,
	input  wire logic [ACC_W-1:0] freq,
	output logic      [ACC_W-1:0] phase,
	output logic      [DAC_W-1:0] dac
);
	logic [ACC_W-1:0] phase_nxt;
	logic [DAC_W-1:0] dac_nxt;
	logic [3:0]       qidx;
	logic [9:0]       mag;

	function automatic logic [9:0] quarter_sine(input logic [3:0] i);
		unique case (i)
			4'h0: quarter_sine = 10'h032;
			4'h1: quarter_sine = 10'h096;
			4'h2: quarter_sine = 10'h0F9;
			4'h3: quarter_sine = 10'h159;
			4'h4: quarter_sine = 10'h1B5;
			4'h5: quarter_sine = 10'h20E;
			4'h6: quarter_sine = 10'h261;
			4'h7: quarter_sine = 10'h2AF;
			4'h8: quarter_sine = 10'h2F6;
			4'h9: quarter_sine = 10'h336;
			4'hA: quarter_sine = 10'h36D;
			4'hB: quarter_sine = 10'h39D;
			4'hC: quarter_sine = 10'h3C3;
			4'hD: quarter_sine = 10'h3E0;
			4'hE: quarter_sine = 10'h3F4;
			4'hF: quarter_sine = 10'h3FE;
		endcase
	endfunction

	always_comb begin
		// Plain modulo add, wraps on overflow
		phase_nxt = run ? phase + freq : phase;
		qidx = phase[ACC_W-2] ? ~phase[ACC_W-3 -: 4] : phase[ACC_W-3 -: 4];
		mag  = quarter_sine(qidx);
		// Offset binary around mid-scale
		dac_nxt = phase[ACC_W-1] ? DAC_W'(11'h400 - {1'b0, mag})
			: DAC_W'(11'h400 + {1'b0, mag});
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= '0;
			dac   <= DAC_W'(11'h400);
		end else begin
			phase <= phase_nxt;
			dac   <= dac_nxt;
		end
	end
endmodule

// ---- verif/ddsfsk_mcu_model.sv ----
`timescale 1ns/1ns
module ddsfsk_mcu_model (
	input  wire logic hclk,
	input  wire logic want_mode,
	input  wire logic want_tx,
	input  wire logic receiving,
	output logic      mode_select,
	output logic      tx_data
);
	initial begin
		mode_select = 1'h0;
		tx_data     = 1'h0;
	end
	// Port pins change just after the edge, like a firmware port write
	always @(posedge hclk) begin
		mode_select <= want_mode;
		tx_data     <= want_tx & ~receiving;
	end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        mode_select;
	logic        tx_data;
	logic        standby;
	logic        pll_lock;
	logic [7:0]  demod_sample;
	logic [7:0]  thr_node;
	logic [10:0] dac_out;
	logic [9:0]  div_ratio;
	logic        acq_pump_out;
	logic [2:0]  acq_aid_gain;
	logic        osc_enable;
	logic [7:0]  afc_tune;
	logic        data_out;
	logic        want_mode;
	logic        want_tx;
	logic        receiving;
	logic [31:0] rd;
	logic [7:0]  held;
	int          miscompares;
	int          checks_done;
	int          cyc;

	ddsfsk_top #(.DAC_W(11)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mode_select(mode_select), .tx_data(tx_data), .standby(standby),
		.pll_lock(pll_lock), .demod_sample(demod_sample), .threshold_hold_node(thr_node),
		.dac_out(dac_out), .div_ratio(div_ratio), .acq_pump_out(acq_pump_out),
		.acq_aid_gain(acq_aid_gain), .osc_enable(osc_enable), .afc_tune(afc_tune),
		.data_out(data_out)
	);
	ddsfsk_mcu_model mcu (
		.hclk(hclk), .want_mode(want_mode), .want_tx(want_tx), .receiving(receiving),
		.mode_select(mode_select), .tx_data(tx_data)
	);

	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) cyc <= cyc + 1;

	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task cyc_wait(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Bounded wait for hready sampled high at a rising edge
	task wait_rdy(output int t);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 20);
		if (hreadyout !== 1'h1) begin
			miscompares++;
			end_of_test();
		end
		t = cyc;
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output int t);
		int u;
		hsel   <= 1'h1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy(t);
		htrans <= 2'h0;
		hsel   <= 1'h0;
		hwdata <= wd;
		wait_rdy(u);
		r = hrdata;
		chk("hresp", 32'(hresp), 32'h0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		bus(1'h1, a, d, rd, t);
	endtask

	task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
		int t;
		bus(1'h0, a, 32'h0, rd, t);
		chk(name, rd, e);
	endtask

	// Two phase reads; the advance must equal the step times the cycles between them
	task step(input logic [23:0] f);
		logic [31:0] p1;
		int          t1;
		int          t2;
		bus(1'h0, ddsfsk_pkg::OFS_PHASE, 32'h0, p1, t1);
		bus(1'h0, ddsfsk_pkg::OFS_PHASE, 32'h0, rd, t2);
		chk("phase_step", {8'h00, rd[23:0] - p1[23:0]}, {8'h00, 24'(f * 24'(t2 - t1))});
	endtask

	task sc_reset;
		chk("hreadyout", 32'(hreadyout), 32'h1);
		chk("div_ratio", 32'(div_ratio), 32'h100);
		chk("osc_enable", 32'(osc_enable), 32'h1);
		rdc("cfg", ddsfsk_pkg::OFS_CFG, 32'h00011000);
		rdc("freq0", ddsfsk_pkg::OFS_FREQ0, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rdc("unmapped", 8'h20, 32'h0);
	endtask

	task sc_words;
		wr(ddsfsk_pkg::OFS_FREQ0, 32'hFFFFFFFF);
		rdc("freq0", ddsfsk_pkg::OFS_FREQ0, 32'h003FFFFF);
		wr(ddsfsk_pkg::OFS_FREQ1, 32'hC0123456);
		rdc("freq1", ddsfsk_pkg::OFS_FREQ1, 32'h00123456);
		step(24'h3FFFFF);
	endtask

	task sc_mode;
		want_mode <= 1'h1;
		cyc_wait(6);
		step(24'h123456);
		want_mode <= 1'h0;
		cyc_wait(6);
		step(24'h3FFFFF);
	endtask

	task sc_fsk;
		wr(ddsfsk_pkg::OFS_CFG, 32'h0000107F);
		want_tx <= 1'h1;
		cyc_wait(6);
		step(24'h4001FB);
		receiving <= 1'h1;
		cyc_wait(6);
		step(24'h3FFFFF);
		receiving <= 1'h0;
		wr(ddsfsk_pkg::OFS_CFG, 32'h0001107F);
		cyc_wait(6);
		step(24'h3FFFFF);
		want_tx <= 1'h0;
	endtask

	task sc_standby;
		standby <= 1'h1;
		cyc_wait(3);
		step(24'h0);
		chk("dac_sign", 32'(dac_out[10]), 32'(!rd[23]));
		standby <= 1'h0;
		rdc("freq0", ddsfsk_pkg::OFS_FREQ0, 32'h003FFFFF);
		step(24'h3FFFFF);
	endtask

	task sc_pll;
		chk("pump_unlocked", 32'(acq_pump_out), 32'h1);
		pll_lock <= 1'h1;
		cyc_wait(5);
		chk("pump_locked", 32'(acq_pump_out), 32'h0);
		rdc("status", ddsfsk_pkg::OFS_STATUS, 32'h00000001);
		pll_lock <= 1'h0;
		cyc_wait(5);
		chk("pump_relock", 32'(acq_pump_out), 32'h1);
		// External oscillator in use: firmware clears the enable
		wr(ddsfsk_pkg::OFS_CFG, 32'h00010D00);
		cyc_wait(2);
		chk("div_ratio", 32'(div_ratio), 32'h200);
		chk("acq_aid_gain", 32'(acq_aid_gain), 32'h5);
		chk("osc_enable", 32'(osc_enable), 32'h0);
		wr(ddsfsk_pkg::OFS_CFG, 32'h00011200);
		cyc_wait(2);
		chk("div_ratio", 32'(div_ratio), 32'h100);
		chk("acq_aid_gain", 32'(acq_aid_gain), 32'h2);
	endtask

	task sc_slicer;
		demod_sample <= 8'hFF;
		cyc_wait(100);
		chk("afc_learn", 32'(afc_tune > 8'h80), 32'h1);
		chk("data_learn", 32'(data_out), 32'h1);
		wr(ddsfsk_pkg::OFS_CFG, 32'h00013000);
		cyc_wait(2);
		held = afc_tune;
		demod_sample <= 8'h90;
		cyc_wait(20);
		chk("afc_hold", 32'(afc_tune), 32'(held));
		chk("data_hold", 32'(data_out), 32'h0);
		thr_node <= 8'h10;
		wr(ddsfsk_pkg::OFS_CFG, 32'h00017000);
		demod_sample <= 8'h20;
		cyc_wait(3);
		chk("data_ext_hi", 32'(data_out), 32'h1);
		demod_sample <= 8'h08;
		cyc_wait(3);
		chk("data_ext_lo", 32'(data_out), 32'h0);
	endtask

	initial begin
		hresetn      = 1'h0;
		hsel         = 1'h0;
		haddr        = 32'h0;
		htrans       = 2'h0;
		hwrite       = 1'h0;
		hsize        = 3'h2;
		hwdata       = 32'h0;
		standby      = 1'h0;
		pll_lock     = 1'h0;
		demod_sample = 8'h80;
		thr_node     = 8'h00;
		want_mode    = 1'h0;
		want_tx      = 1'h0;
		receiving    = 1'h0;
		miscompares  = 0;
		checks_done  = 0;
		cyc          = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		sc_reset();
		sc_words();
		sc_mode();
		sc_fsk();
		sc_standby();
		sc_pll();
		sc_slicer();
		end_of_test();
	end
endmodule
